// ---- rtl/fetp_pkg.sv ----
// How it works
// - Eight-bit persistent training pattern, default 00h, used during DDR dummy cycles.
// - Any reset loads the working pattern from the persistent pattern.
// - The working pattern is what reaches the data outputs.
// - Host may rewrite the working pattern; persistent copy stays untouched.
// - Decode correction commands: read B3h, write B5h, clear B6h.
// - Correction bit 0: writable disable, 0 means correction on, resets 0.
// - Correction bit 1: read-only event flag, set by a correction, resets 0.
// - Bits 5:2 count corrections, reset 0000, saturate at 15.
// - With correction on, repeat programming is ignored and bit 6 set.
// - Two dies; reads return the die that the dieSel input currently selects.
// - Write-protect pin guards block-protect, write-disable and quad-enable bits.
// - Status writes blocked only when write-disable is 1 and pin low.
// - Program, erase or register write ignored while write-enable latch clear.
// - Sector protection stays usable outside the block-protected range.
// - A block is protected if either protection scheme protects it.
// - Four block-protect bits select part of the array up to all of it.
// - Decode training commands: read 41h, program persistent 43h, write working 4Ah.
// - The data-training phase emits the working pattern.
package fetp_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_RD_TRAIN   = 8'h41;
  localparam logic [7:0] OP_PROG_TRAIN = 8'h43;
  localparam logic [7:0] OP_WR_TRAIN   = 8'h4A;
  localparam logic [7:0] OP_RD_CORR    = 8'hB3;
  localparam logic [7:0] OP_WR_CORR    = 8'hB5;
  localparam logic [7:0] OP_CLR_CORR   = 8'hB6;
  // ==========================================================
  // Field layouts
  localparam int         TRAIN_W      = 8;
  localparam int         CORR_DIS_BIT = 0;
  localparam int         CORR_CNT_W   = 4;
  localparam int         SR_NV_W      = 6;
  localparam int         SR_NV_LSB    = 2;
  localparam int         DIE_COUNT    = 2;
  localparam logic [3:0] CORR_CNT_MAX = 4'hF;
  // ==========================================================
  // Reset values
  localparam logic [7:0] TRAIN_RST = 8'h00;
  localparam logic [3:0] CNT_RST   = 4'h0;
  localparam logic [5:0] SR_NV_RST = 6'h00;
  // ==========================================================
  // Link framing, counted in serial clock edges
  localparam logic [4:0] LAST_OP_BIT   = 5'h07;
  localparam logic [4:0] FIRST_RD_BIT  = 5'h08;
  localparam logic [4:0] LAST_DATA_BIT = 5'h0F;
  localparam logic [4:0] FRAME_BITS    = 5'h10;
endpackage : fetp_pkg

// ---- rtl/fetp_nv_cell.sv ----
`timescale 1ns/1ps
`default_nettype none
// Persistent storage word; kept through ordinary resets, cleared only at power-on
module fetp_nv_cell #(
  parameter int             W    = 8,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         porRst_n,
  input  wire logic         write_enable_cmd,
  input  wire logic [W-1:0] wrData,
  output var  logic [W-1:0] rdData
);
  logic [W-1:0] cell_r;
  logic [W-1:0] rdData_r;

  always_ff @(posedge clk) begin
    if (!porRst_n) begin
      cell_r <= INIT;
    end else if (write_enable_cmd) begin
      cell_r <= wrData;
    end
  end

  // Registered read port keeps the storage off combinational paths
  always_ff @(posedge clk) begin
    rdData_r <= cell_r;
  end

  assign rdData = rdData_r;
endmodule : fetp_nv_cell
`default_nettype wire

// ---- rtl/fetp_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module fetp_regs
  import fetp_pkg::*;
#(
  parameter int         BLK_W        = 10,
  parameter logic [7:0] OP_WR_ENABLE = 8'h06,
  parameter logic [7:0] OP_RD_STATUS = 8'h05,
  parameter logic [7:0] OP_WR_STATUS = 8'h01
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             porRst_n,
  input  wire logic             spiClk,
  input  wire logic             csN,
  input  wire logic             si,
  output var  logic             soOut,
  output var  logic             soOe,
  input  wire logic             wpN,
  input  wire logic             dieSel,
  input  wire logic             corrEvent,
  input  wire logic             reprogAttempt,
  input  wire logic             arrayOpReq,
  input  wire logic [BLK_W-1:0] arrayOpBlock,
  input  wire logic             aspProtect,
  input  wire logic             trainReq,
  output var  logic             arrayOpGo,
  output var  logic             reprogIgnored,
  output var  logic             corrEnabled,
  output var  logic             trainActive,
  output var  logic [7:0]       trainPattern
);

  // ==========================================================
  // Functions

  function automatic logic [3:0] satInc(input logic [3:0] v);
    satInc = (v == CORR_CNT_MAX) ? v : v + 4'h1;
  endfunction : satInc

  // Protected region is the top 2^(bp-1) blocks; large codes cover all
  function automatic logic bpCovers(input logic [3:0] bp, input logic [BLK_W-1:0] blk);
    logic [BLK_W-1:0] inv;
    inv      = ~blk;
    bpCovers = (bp != 4'h0) && ((inv >> (bp - 4'h1)) == '0);
  endfunction : bpCovers

  // ==========================================================
  // Link side, serial clock domain

  logic [4:0] bitCnt_r;
  logic [7:0] opShift_r;
  logic [7:0] dataShift_r;
  logic       opTgl_r;
  logic       hasData_r;
  logic [7:0] rdShift_r;
  logic       soOut_r;
  logic       soOe_r;

  // Snapshots owned by the system domain, frozen while a frame runs
  logic [7:0] snapPat_r;
  logic [7:0] snapCorr_r;
  logic [7:0] snapStat_r;

  wire logic       rdOp   = (opShift_r == OP_RD_TRAIN) || (opShift_r == OP_RD_CORR) ||
                            (opShift_r == OP_RD_STATUS);
  wire logic [7:0] rdByte = (opShift_r == OP_RD_TRAIN) ? snapPat_r :
                            (opShift_r == OP_RD_CORR)  ? snapCorr_r : snapStat_r;

  always_ff @(posedge spiClk or posedge csN) begin
    if (csN) begin
      bitCnt_r <= 5'h00;
    end else if (bitCnt_r != FRAME_BITS) begin
      bitCnt_r <= bitCnt_r + 5'h01;
    end
  end

  // Shift registers are not cleared by chip select so the system side can
  // still read them after the frame has ended
  always_ff @(posedge spiClk) begin
    if (bitCnt_r <= LAST_OP_BIT) begin
      opShift_r <= {opShift_r[6:0], si};
    end else if (bitCnt_r <= LAST_DATA_BIT) begin
      dataShift_r <= {dataShift_r[6:0], si};
    end
  end

  always_ff @(posedge spiClk or negedge rst_n) begin
    if (!rst_n) begin
      opTgl_r   <= 1'h0;
      hasData_r <= 1'h0;
    end else if (!csN) begin
      if (bitCnt_r == LAST_OP_BIT) begin
        opTgl_r   <= ~opTgl_r;
        hasData_r <= 1'h0;
      end
      if (bitCnt_r == LAST_DATA_BIT) begin
        hasData_r <= 1'h1;
      end
    end
  end

  // Mode 0: output changes on the falling edge, host samples on the rising
  always_ff @(negedge spiClk or posedge csN) begin
    if (csN) begin
      soOut_r   <= 1'h0;
      soOe_r    <= 1'h0;
      rdShift_r <= 8'h00;
    end else if (bitCnt_r == FIRST_RD_BIT) begin
      soOe_r    <= rdOp;
      soOut_r   <= rdByte[7];
      rdShift_r <= {rdByte[6:0], 1'h0};
    end else begin
      soOut_r   <= rdShift_r[7];
      rdShift_r <= {rdShift_r[6:0], 1'h0};
    end
  end

  assign soOut = soOut_r;
  assign soOe  = soOe_r;

  // ==========================================================
  // Crossing into the system clock

  logic [2:0] csS_r;
  logic [2:0] wpS_r;
  logic [2:0] tglS_r;
  logic       csIdle_r;
  logic       wpHigh_r;
  logic       tglLvl_r;
  logic       tglSeen_r;

  wire logic csAgree  = csS_r[1] == csS_r[2];
  wire logic tglAgree = tglS_r[1] == tglS_r[2];
  wire logic wpAgree  = wpS_r[1] == wpS_r[2];
  wire logic frameEnd = csAgree && csS_r[2] && !csIdle_r;
  wire logic newOp    = tglLvl_r != tglSeen_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      csS_r  <= 3'h7;
      wpS_r  <= 3'h7;
      tglS_r <= 3'h0;
    end else begin
      csS_r  <= {csS_r[1:0], csN};
      wpS_r  <= {wpS_r[1:0], wpN};
      tglS_r <= {tglS_r[1:0], opTgl_r};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      csIdle_r  <= 1'h1;
      wpHigh_r  <= 1'h1;
      tglLvl_r  <= 1'h0;
      tglSeen_r <= 1'h0;
    end else begin
      csIdle_r  <= csAgree  ? csS_r[2]  : csIdle_r;
      wpHigh_r  <= wpAgree  ? wpS_r[2]  : wpHigh_r;
      tglLvl_r  <= tglAgree ? tglS_r[2] : tglLvl_r;
      tglSeen_r <= frameEnd ? tglLvl_r  : tglSeen_r;
    end
  end

  // Frame contents are stable here because the serial clock has stopped
  logic       cmdGo_r;
  logic       cmdHasData_r;
  logic [7:0] cmdOp_r;
  logic [7:0] cmdData_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmdGo_r      <= 1'h0;
      cmdHasData_r <= 1'h0;
      cmdOp_r      <= 8'h00;
      cmdData_r    <= 8'h00;
    end else begin
      cmdGo_r <= frameEnd && newOp;
      if (frameEnd && newOp) begin
        cmdHasData_r <= hasData_r;
        cmdOp_r      <= opShift_r;
        cmdData_r    <= dataShift_r;
      end
    end
  end

  // ==========================================================
  // Command decode

  logic       wel_r;
  logic [5:0] srNv;
  logic [7:0] nvPat;

  wire logic [3:0] blockProt   = srNv[3:0];
  wire logic       quadEnable  = srNv[4];
  wire logic       statusWrDis = srNv[5];

  wire logic goData    = cmdGo_r && cmdHasData_r;
  wire logic isWrEn    = cmdGo_r && (cmdOp_r == OP_WR_ENABLE);
  wire logic isWrStat  = goData && (cmdOp_r == OP_WR_STATUS);
  wire logic isProgPat = goData && (cmdOp_r == OP_PROG_TRAIN);
  wire logic isWrPat   = goData && (cmdOp_r == OP_WR_TRAIN);
  wire logic isWrCorr  = goData && (cmdOp_r == OP_WR_CORR);
  wire logic isClrCorr = cmdGo_r && (cmdOp_r == OP_CLR_CORR);

  wire logic statusLocked = statusWrDis && !wpHigh_r;
  wire logic regWrite     = isWrStat || isProgPat || isWrPat || isWrCorr;
  wire logic srWrite      = isWrStat && wel_r && !statusLocked;
  wire logic patNvWrite   = isProgPat && wel_r;
  wire logic patWkWrite   = isWrPat && wel_r;
  wire logic corrWrite    = isWrCorr && wel_r;

  wire logic blkCovered = bpCovers(blockProt, arrayOpBlock);
  wire logic blkLocked  = blkCovered || aspProtect;
  wire logic arrayOk    = arrayOpReq && wel_r && !blkLocked;
  wire logic welUsed    = wel_r && (regWrite || arrayOpReq);

  // Write-enable latch; a new enable wins over a same-cycle consumption
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wel_r <= 1'h0;
    end else if (isWrEn) begin
      wel_r <= 1'h1;
    end else if (welUsed) begin
      wel_r <= 1'h0;
    end
  end

  // ==========================================================
  // Persistent storage

  fetp_nv_cell #(
    .W    (SR_NV_W),
    .INIT (SR_NV_RST)
  ) u_status_nv (
    .clk      (sys_clk),
    .porRst_n (porRst_n),
    .write_enable_cmd     (srWrite),
    .wrData   (cmdData_r[7:SR_NV_LSB]),
    .rdData   (srNv)
  );

  fetp_nv_cell #(
    .W    (TRAIN_W),
    .INIT (TRAIN_RST)
  ) u_pattern_nv (
    .clk      (sys_clk),
    .porRst_n (porRst_n),
    .write_enable_cmd     (patNvWrite),
    .wrData   (cmdData_r),
    .rdData   (nvPat)
  );

  // ==========================================================
  // Working training pattern

  logic       loadPend_r;
  logic [7:0] workPat_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !porRst_n) begin
      loadPend_r <= 1'h1;
      workPat_r  <= TRAIN_RST;
    end else if (loadPend_r) begin
      loadPend_r <= 1'h0;
      workPat_r  <= nvPat;
    end else if (patWkWrite) begin
      workPat_r  <= cmdData_r;
    end
  end

  // ==========================================================
  // Correction status, one set per die

  logic            corrDis_r [DIE_COUNT];
  logic            corrEvt_r [DIE_COUNT];
  logic            corrIpa_r [DIE_COUNT];
  logic [3:0]      corrCnt_r [DIE_COUNT];

  for (genvar d = 0; d < DIE_COUNT; d++) begin : g_die
    wire logic hit    = dieSel == 1'(d);
    wire logic clr    = hit && isClrCorr;
    wire logic active = !corrDis_r[d];
    wire logic [3:0] base = clr ? CNT_RST : corrCnt_r[d];

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        corrDis_r[d] <= 1'h0;
        corrEvt_r[d] <= 1'h0;
        corrIpa_r[d] <= 1'h0;
        corrCnt_r[d] <= CNT_RST;
      end else begin
        if (hit && corrWrite) begin
          corrDis_r[d] <= cmdData_r[CORR_DIS_BIT];
        end
        // Clear comes first so a same-cycle event still lands
        if (clr) begin
          corrEvt_r[d] <= 1'h0;
          corrIpa_r[d] <= 1'h0;
          corrCnt_r[d] <= CNT_RST;
        end
        if (hit && corrEvent && active) begin
          corrEvt_r[d] <= 1'h1;
          corrCnt_r[d] <= satInc(base);
        end
        if (hit && reprogAttempt && active) begin
          corrIpa_r[d] <= 1'h1;
        end
      end
    end
  end

  wire logic       selDis  = corrDis_r[dieSel];
  wire logic [7:0] corrReg = {1'h0, corrIpa_r[dieSel], corrCnt_r[dieSel],
                              corrEvt_r[dieSel], selDis};
  wire logic [7:0] statReg = {srNv, wel_r, 1'h0};

  // ==========================================================
  // Read snapshots and block outputs

  logic       arrayOpGo_r;
  logic       reprogIgn_r;
  logic       corrEn_r;
  logic       trainAct_r;
  logic [7:0] trainPat_r;

  // Snapshot only while idle; the link reads it mid-frame without handshake
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      snapPat_r  <= TRAIN_RST;
      snapCorr_r <= 8'h00;
      snapStat_r <= 8'h00;
    end else if (csIdle_r) begin
      snapPat_r  <= workPat_r;
      snapCorr_r <= corrReg;
      snapStat_r <= statReg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arrayOpGo_r <= 1'h0;
      reprogIgn_r <= 1'h0;
      corrEn_r    <= 1'h1;
      trainAct_r  <= 1'h0;
      trainPat_r  <= TRAIN_RST;
    end else begin
      arrayOpGo_r <= arrayOk;
      reprogIgn_r <= reprogAttempt && !selDis;
      corrEn_r    <= !selDis;
      trainAct_r  <= trainReq;
      trainPat_r  <= workPat_r;
    end
  end

  assign arrayOpGo     = arrayOpGo_r;
  assign reprogIgnored = reprogIgn_r;
  assign corrEnabled   = corrEn_r;
  assign trainActive   = trainAct_r;
  assign trainPattern  = trainPat_r;

  // Quad enable is stored and reported only; lane switching lives elsewhere
  wire logic unusedQuad = quadEnable;

endmodule : fetp_regs
`default_nettype wire

// ---- test/fetp_regs_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module fetp_regs_properties
  import fetp_pkg::*;
#(
  parameter int BLK_W = 10
) (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             porRst_n,
  input wire logic             spiClk,
  input wire logic             csN,
  input wire logic             si,
  input wire logic             soOut,
  input wire logic             soOe,
  input wire logic             wpN,
  input wire logic             dieSel,
  input wire logic             corrEvent,
  input wire logic             reprogAttempt,
  input wire logic             arrayOpReq,
  input wire logic [BLK_W-1:0] arrayOpBlock,
  input wire logic             aspProtect,
  input wire logic             trainReq,
  input wire logic             arrayOpGo,
  input wire logic             reprogIgnored,
  input wire logic             corrEnabled,
  input wire logic             trainActive,
  input wire logic [7:0]       trainPattern
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Sequences
  sequence s_quiet;
    !arrayOpGo [*8];
  endsequence
  sequence s_steady;
    $stable(corrEnabled) && $stable(dieSel);
  endsequence
  // ==========================================================
  // Properties
  property p_go_cause;
    arrayOpGo |-> $past(arrayOpReq) && !$past(aspProtect);
  endproperty
  property p_go_once;
    arrayOpGo |=> s_quiet;
  endproperty
  property p_asp_block;
    arrayOpReq && aspProtect |=> !arrayOpGo;
  endproperty
  property p_ign_on;
    (reprogAttempt && corrEnabled) and s_steady |=> reprogIgnored;
  endproperty
  property p_ign_off;
    (reprogAttempt && !corrEnabled) and s_steady |=> !reprogIgnored;
  endproperty
  // Enable output lags the selected die by one cycle, as the ignore pulse does
  property p_ign_cause;
    reprogIgnored |-> $past(reprogAttempt) && corrEnabled;
  endproperty
  property p_train_on;
    trainReq |=> trainActive;
  endproperty
  property p_train_off;
    !trainReq |=> !trainActive;
  endproperty
  property p_so_idle;
    csN |-> !soOe;
  endproperty
  // Working pattern only moves once a frame has closed
  property p_pat_hold;
    $changed(trainPattern) |-> $past(csN, 3);
  endproperty
  a_go_cause:  assert property (p_go_cause)  else $error("array go without request");
  a_go_once:   assert property (p_go_once)   else $error("latch not consumed");
  a_asp_block: assert property (p_asp_block) else $error("sector lock ignored");
  a_ign_on:    assert property (p_ign_on)    else $error("repeat not ignored");
  a_ign_off:   assert property (p_ign_off)   else $error("repeat flagged while off");
  a_ign_cause: assert property (p_ign_cause) else $error("spurious ignore");
  a_train_on:  assert property (p_train_on)  else $error("training not active");
  a_train_off: assert property (p_train_off) else $error("training stuck");
  a_so_idle:   assert property (p_so_idle)   else $error("so driven while idle");
  a_pat_hold:  assert property (p_pat_hold)  else $error("pattern moved mid frame");
endmodule : fetp_regs_properties
bind fetp_regs fetp_regs_properties #(.BLK_W(BLK_W)) chk_u (.*);
`default_nettype wire

// ---- test/fetp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module fetp_host (
  output var  logic       spiClk,
  output var  logic       csN,
  output var  logic       si,
  input  wire logic       soOut,
  output var  logic [7:0] rdByte,
  output var  logic       rdStb
);
  localparam realtime HALF = 62.5;
  initial begin
    spiClk = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    rdByte = 8'h00;
    rdStb = 1'b0;
  end
  // ==========================================================
  // Mode 0 frame; clock stands low between frames
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nb, input logic rd);
    logic [15:0] sh;
    sh = {op, dat};
    #1.3;
    csN = 1'b0;
    for (int i = 0; i < nb; i++) begin
      si = sh[15-i];
      #(HALF);
      spiClk = 1'b1;
      if (i >= 8) rdByte = {rdByte[6:0], soOut};
      #(HALF);
      spiClk = 1'b0;
    end
    #(HALF);
    csN = 1'b1;
    // Released line shows the inverse so a stale bit is never trusted
    si = ~si;
    if (rd) rdStb = 1'b1;
    #150;
    rdStb = 1'b0;
  endtask : xfer
endmodule : fetp_host
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fetp_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, porRst_n = 1'b0, spiClk, csN, si, soOut, soOe;
  logic wpN, dieSel, corrEvent, reprogAttempt, arrayOpReq, aspProtect, trainReq, arrayOpGo;
  logic reprogIgnored, corrEnabled, trainActive, rdStb, w;
  logic [9:0] arrayOpBlock, b;
  logic [7:0] trainPattern, rdByte, v, p;
  logic [7:0] expQ[$];
  int num_errors = 0, num_checks = 0, seed = 99;
  fetp_regs dut_u (.*);
  fetp_host host_u (.*);
  always #2.5 sys_clk = ~sys_clk;
  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic do_reset(input logic por);
    @(negedge sys_clk);
    rst_n = 1'b0;
    porRst_n = ~por;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    porRst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : do_reset
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    expQ.push_back(exp);
    host_u.xfer(op, 8'h00, 16, 1'b1);
  endtask : rd
  task automatic wr(input logic [7:0] op, input logic [7:0] dat);
    host_u.xfer(dut_u.OP_WR_ENABLE, 8'h00, 8, 1'b0);
    host_u.xfer(op, dat, 16, 1'b0);
  endtask : wr
  task automatic pulse(input logic rep, input logic expIgn);
    @(negedge sys_clk);
    corrEvent = ~rep;
    reprogAttempt = rep;
    @(negedge sys_clk);
    corrEvent = 1'b0;
    reprogAttempt = 1'b0;
    if (rep) chk({7'h00, reprogIgnored}, {7'h00, expIgn});
  endtask : pulse
  task automatic aop(input logic [9:0] blk, input logic advanced_sector_protection, input logic en, input logic exp);
    if (en) host_u.xfer(dut_u.OP_WR_ENABLE, 8'h00, 8, 1'b0);
    @(negedge sys_clk);
    arrayOpReq = 1'b1;
    arrayOpBlock = blk;
    aspProtect = advanced_sector_protection;
    @(negedge sys_clk);
    arrayOpReq = 1'b0;
    chk({7'h00, arrayOpGo}, {7'h00, exp});
  endtask : aop
  // ==========================================================
  // Read results are matched in order against the notes
  always @(posedge rdStb) begin
    if (expQ.size() == 0) chk(8'hXX, 8'h00);
    else chk(rdByte, expQ.pop_front());
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    close_out();
  end
  initial begin
    {corrEvent, reprogAttempt, arrayOpReq, aspProtect, trainReq, dieSel} = '0;
    {wpN, arrayOpBlock} = {1'b1, 10'h000};
    do_reset(1'b1);
    rd(OP_RD_TRAIN, TRAIN_RST);
    rd(OP_RD_CORR, 8'h00);
    host_u.xfer(OP_WR_TRAIN, 8'h5A, 16, 1'b0);
    rd(OP_RD_TRAIN, TRAIN_RST);
    v = $random(seed);
    wr(OP_WR_TRAIN, v);
    rd(OP_RD_TRAIN, v);
    @(negedge sys_clk);
    trainReq = 1'b1;
    @(negedge sys_clk);
    chk(trainPattern, v);
    chk({7'h00, trainActive}, 8'h01);
    trainReq = 1'b0;
    p = $random(seed);
    wr(OP_PROG_TRAIN, p);
    rd(OP_RD_TRAIN, v);
    do_reset(1'b0);
    rd(OP_RD_TRAIN, p);
    chk(trainPattern, p);
    do_reset(1'b1);
    rd(OP_RD_TRAIN, TRAIN_RST);
    $display("test done: training pattern");
    repeat (17) pulse(1'b0, 1'b0);
    rd(OP_RD_CORR, 8'h3E);
    pulse(1'b1, 1'b1);
    rd(OP_RD_CORR, 8'h7E);
    @(negedge sys_clk);
    dieSel = 1'b1;
    rd(OP_RD_CORR, 8'h00);
    @(negedge sys_clk);
    dieSel = 1'b0;
    host_u.xfer(OP_CLR_CORR, 8'h00, 8, 1'b0);
    rd(OP_RD_CORR, 8'h00);
    wr(OP_WR_CORR, 8'hFF);
    rd(OP_RD_CORR, 8'h01);
    chk({7'h00, corrEnabled}, 8'h00);
    pulse(1'b0, 1'b0);
    pulse(1'b1, 1'b0);
    host_u.xfer(OP_CLR_CORR, 8'h00, 8, 1'b0);
    rd(OP_RD_CORR, 8'h01);
    wr(OP_WR_CORR, 8'h00);
    $display("test done: correction register");
    for (int i = 0; i < 4; i++) begin
      w = i[1];
      wpN = 1'b1;
      wr(dut_u.OP_WR_STATUS, {w, 7'h00});
      wpN = i[0];
      wr(dut_u.OP_WR_STATUS, {w, 7'h54});
      rd(dut_u.OP_RD_STATUS, (w && !i[0]) ? {w, 7'h00} : {w, 7'h54});
    end
    $display("test done: write protect");
    b = 10'({$random(seed)} % 1008);
    aop(b, 1'b0, 1'b1, 1'b1);
    aop(b, 1'b0, 1'b0, 1'b0);
    aop(10'h3FF, 1'b0, 1'b1, 1'b0);
    aop(10'h3F0, 1'b0, 1'b1, 1'b0);
    aop(10'h3EF, 1'b0, 1'b1, 1'b1);
    aop(b, 1'b1, 1'b1, 1'b0);
    aop(10'h3F8, 1'b1, 1'b1, 1'b0);
    $display("test done: array protection");
    close_out();
  end
endmodule : testbench
`default_nettype wire
